/* File: shared/cdc_consts.svh */
// constants for the cassette device control block
`ifndef CDC_CONSTS_SVH
`define CDC_CONSTS_SVH
`define CDC_ADDR_CTRL 4'h0
`define CDC_ADDR_INHIBIT 4'h1
`define CDC_ADDR_STATUS 4'h2
`define CDC_ADDR_IRQ_STAT 4'h3
`define CDC_ADDR_IRQ_MASK 4'h4
`define CDC_CH_PB_ON 7'h11
`define CDC_CH_REC_ON 7'h12
`define CDC_CH_PB_OFF 7'h13
`define CDC_CH_REC_OFF 7'h14
`define CDC_CH_ETX 7'h03
`define CDC_CH_CR 7'h0d
`define CDC_BLOCK_LEN 7'h56
`define CDC_CTRL_AUTO 0
`define CDC_CTRL_STOPERR 1
`define CDC_CTRL_ETX 2
`define CDC_CTRL_BINARY 3
`define CDC_CTRL_CONTINUOUS_TAPE_FORMAT 4
`define CDC_CTRL_RESET 5'h11
`define CDC_INHIBIT_RESET 12'h000
`define CDC_EV_PB 0
`define CDC_EV_REC 1
`define CDC_EV_ERR 2
`define CDC_EV_BLOCK 3
`endif

/* File: shared/cdc_pkg.sv */
// types for the cassette device control block
package cdc_pkg;
   typedef enum logic [1:0] {
      CDC_SRC_TX = 2'b00,
      CDC_SRC_RX = 2'b01,
      CDC_SRC_LOCAL = 2'b10
   } cdc_src_t;
   typedef struct packed {
      logic valid;
      cdc_src_t src;
      logic [7:0] data;
   } cdc_char_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cdc_bus_t;
   typedef enum logic [1:0] {
      CDC_PB_IDLE = 2'b00,
      CDC_PB_RUN = 2'b01,
      CDC_PB_LAST = 2'b10
   } cdc_pb_state_t;
   typedef struct packed {
      logic pbOn;
      logic recOn;
      cdc_pb_state_t pbState;
      logic [6:0] fill;
      logic [4:0] ctrl;
      logic [11:0] inhibit;
      logic [3:0] irqStat;
      logic [3:0] irqMask;
      logic [31:0] rdata;
      logic recStart;
      logic pbSend;
      logic [7:0] pbData;
   } cdc_state_t;
endpackage : cdc_pkg

/* File: verilog/cdc_top.sv */
// cassette transport control driven by in-band device control characters
`timescale 1ns/1ps
`default_nettype none
`include "cdc_consts.svh"

module cdc_top
   import cdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire cdc_char_t lineChar,
   input wire cdc_char_t tapeChar,
   input wire logic tapeReadErr,
   input wire cdc_bus_t bus,
   output logic [31:0] rdata,
   output logic playbackOn,
   output logic recordOn,
   output logic recordStart,
   output logic pbSendValid,
   output logic [7:0] pbSendData,
   output logic irq
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   cdc_state_t s_q;
   cdc_state_t s_d;

   logic autoOn;
   logic etxTrig;
   logic [6:0] code;
   logic [3:0] fn;
   logic [3:0] allow;
   logic [3:0] ev;
   logic [3:0] wrClr;
   logic blockDone;
   logic enter;
   logic tapeStop;

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   always_comb
   begin
      autoOn = s_q.ctrl[`CDC_CTRL_AUTO];
      // binary format overrides the etx strap, so both can never act together
      etxTrig = s_q.ctrl[`CDC_CTRL_ETX] & ~s_q.ctrl[`CDC_CTRL_BINARY];
      code = lineChar.data[6:0];
      fn = 4'h0;
      if (lineChar.valid)
      begin
         fn[0] = (code == `CDC_CH_PB_ON);
         fn[1] = (code == `CDC_CH_REC_ON);
         fn[2] = (code == `CDC_CH_PB_OFF);
         fn[3] = (code == `CDC_CH_REC_OFF);
      end
      // inhibit bits: [3:0] transmit, [7:4] receive, [11:8] local
      unique case (lineChar.src)
         CDC_SRC_TX: allow = ~s_q.inhibit[3:0];
         CDC_SRC_RX: allow = ~s_q.inhibit[7:4];
         CDC_SRC_LOCAL: allow = ~s_q.inhibit[11:8];
         default: allow = 4'h0;
      endcase
      fn = fn & allow & {4{autoOn}};
      // a tape-read stop code only counts when the transmit mode allows it
      tapeStop = tapeChar.valid & autoOn & ~s_q.inhibit[2]
         & (tapeChar.data[6:0] == `CDC_CH_PB_OFF);
      enter = lineChar.valid & s_q.recOn;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.recStart = 1'b0;
      s_d.pbSend = 1'b0;
      blockDone = 1'b0;
      ev = 4'h0;
      wrClr = 4'h0;

      // record transport latch, on wins only if off absent
      if (fn[3])
         s_d.recOn = 1'b0;
      else if (fn[1])
         s_d.recOn = 1'b1;

      // block filling and record start
      if (enter)
      begin
         if (s_q.ctrl[`CDC_CTRL_CONTINUOUS_TAPE_FORMAT])
         begin
            if (etxTrig && code == `CDC_CH_ETX)
               blockDone = 1'b1;
            else if (s_q.fill == `CDC_BLOCK_LEN - 7'h01)
               blockDone = 1'b1;
         end
         else if (code == `CDC_CH_CR || s_q.fill == `CDC_BLOCK_LEN - 7'h01)
            blockDone = 1'b1;
         s_d.fill = blockDone ? 7'h00 : s_q.fill + 7'h01;
      end
      if (!s_d.recOn)
         s_d.fill = 7'h00;
      s_d.recStart = blockDone;

      // playback transport
      unique case (s_q.pbState)
         CDC_PB_IDLE:
         begin
            if (fn[0])
               s_d.pbState = CDC_PB_RUN;
         end
         CDC_PB_RUN:
         begin
            if (fn[2])
               s_d.pbState = CDC_PB_IDLE;
            else if (tapeReadErr && s_q.ctrl[`CDC_CTRL_STOPERR])
               s_d.pbState = CDC_PB_IDLE;
            else if (tapeChar.valid)
            begin
               // errored data still goes out when the stop strap is clear
               s_d.pbSend = 1'b1;
               s_d.pbData = tapeChar.data;
               if (tapeStop)
                  s_d.pbState = CDC_PB_LAST;
            end
         end
         CDC_PB_LAST:
         begin
            if (fn[2] || (tapeReadErr && s_q.ctrl[`CDC_CTRL_STOPERR]))
               s_d.pbState = CDC_PB_IDLE;
            else if (tapeChar.valid)
            begin
               s_d.pbSend = 1'b1;
               s_d.pbData = tapeChar.data;
               s_d.pbState = CDC_PB_IDLE;
            end
         end
         default: s_d.pbState = CDC_PB_IDLE;
      endcase
      s_d.pbOn = (s_d.pbState != CDC_PB_IDLE);

      // register writes
      if (bus.wr)
      begin
         unique case (bus.addr)
            `CDC_ADDR_CTRL: s_d.ctrl = bus.wdata[4:0];
            `CDC_ADDR_INHIBIT: s_d.inhibit = bus.wdata[11:0];
            `CDC_ADDR_IRQ_STAT: wrClr = bus.wdata[3:0];
            `CDC_ADDR_IRQ_MASK: s_d.irqMask = bus.wdata[3:0];
            default: ;
         endcase
      end

      // sticky events, a new event wins over a clear
      ev[`CDC_EV_PB] = s_d.pbOn ^ s_q.pbOn;
      ev[`CDC_EV_REC] = s_d.recOn ^ s_q.recOn;
      ev[`CDC_EV_ERR] = tapeReadErr & s_q.pbOn;
      ev[`CDC_EV_BLOCK] = blockDone;
      s_d.irqStat = (s_q.irqStat & ~wrClr) | ev;

      // read data, one cycle after the strobe, zero elsewhere
      s_d.rdata = 32'h0000_0000;
      if (bus.rd)
      begin
         unique case (bus.addr)
            `CDC_ADDR_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
            `CDC_ADDR_INHIBIT: s_d.rdata = {20'h0, s_q.inhibit};
            `CDC_ADDR_STATUS: s_d.rdata = {21'h0, s_q.fill, s_q.pbState, s_q.recOn, s_q.pbOn};
            `CDC_ADDR_IRQ_STAT: s_d.rdata = {28'h0, s_q.irqStat};
            `CDC_ADDR_IRQ_MASK: s_d.rdata = {28'h0, s_q.irqMask};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.pbState <= CDC_PB_IDLE;
         s_q.ctrl <= `CDC_CTRL_RESET;
         s_q.inhibit <= `CDC_INHIBIT_RESET;
      end
      else
         s_q <= s_d;
   end

   assign rdata = s_q.rdata;
   assign playbackOn = s_q.pbOn;
   assign recordOn = s_q.recOn;
   assign recordStart = s_q.recStart;
   assign pbSendValid = s_q.pbSend;
   assign pbSendData = s_q.pbData;
   assign irq = |(s_q.irqStat & s_q.irqMask);
endmodule : cdc_top
`default_nettype wire

/* File: dv/cdc_top_asserts.sv */
// port checks for cassette device control
`timescale 1ns/1ps
`default_nettype none
module cdc_top_chk
   import cdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire cdc_char_t lineChar,
   input wire cdc_char_t tapeChar,
   input wire logic tapeReadErr,
   input wire cdc_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic playbackOn,
   input wire logic recordOn,
   input wire logic recordStart,
   input wire logic pbSendValid,
   input wire logic [7:0] pbSendData,
   input wire logic irq
);
   // line code of this cycle, zero when idle
   wire logic [6:0] cd = lineChar.valid ? lineChar.data[6:0] : 7'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   pb_on_a: assert property (!$past(rst) && $rose(playbackOn) |-> $past(cd) == 7'h11)
      else $error("bad play on");
   rec_on_a: assert property (!$past(rst) && $rose(recordOn) |-> $past(cd) == 7'h12)
      else $error("bad rec on");
   rec_off_a: assert property (!$past(rst) && $fell(recordOn) |-> $past(cd) == 7'h14)
      else $error("bad rec off");
   pb_off_a: assert property (!$past(rst) && $fell(playbackOn) |->
      $past(cd) == 7'h13 || $past(tapeReadErr) || pbSendValid) else $error("bad play off");
   tape_send_a: assert property (pbSendValid |-> $past(tapeChar.valid && playbackOn) &&
      pbSendData == $past(tapeChar.data)) else $error("bad send");
   rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("bad rdata");
   blk_start_a: assert property (recordStart |-> $past(lineChar.valid))
      else $error("bad block start");
   rst_idle_a: assert property ($fell(rst) |-> !playbackOn && !recordOn && !irq)
      else $error("bad reset state");
endmodule : cdc_top_chk
bind cdc_top cdc_top_chk chk (.clk(clk), .rst(rst), .lineChar(lineChar), .tapeChar(tapeChar),
   .tapeReadErr(tapeReadErr), .bus(bus), .rdata(rdata), .playbackOn(playbackOn),
   .recordOn(recordOn), .recordStart(recordStart), .pbSendValid(pbSendValid),
   .pbSendData(pbSendData), .irq(irq));
`default_nettype wire

/* File: dv/cdc_tape_model.sv */
// tape reader model on the playback side
`timescale 1ns/1ps
`default_nettype none
module cdc_tape_model
   import cdc_pkg::*;
(
   input wire logic clk,
   input wire logic playbackOn,
   input wire logic stopReq,
   input wire logic errReq,
   output cdc_char_t tapeChar,
   output logic tapeReadErr
);
   logic [7:0] seq = 8'h0;
   initial tapeChar = '0;
   initial tapeReadErr = 1'b0;
   // a char every fourth clock; data keeps moving so idle cycles carry no stale value
   always @(posedge clk)
   begin
      seq <= seq + 8'h1;
      tapeChar <= '{playbackOn && seq[1:0] == 2'h3, CDC_SRC_TX,
         stopReq ? 8'h13 : {2'h1, seq[7:2]}};
      tapeReadErr <= errReq && playbackOn;
   end
endmodule : cdc_tape_model
`default_nettype wire

/* File: dv/cdc_top_tb_top.sv */
// self-checking bench for cassette device control
`timescale 1ns/1ps
`default_nettype none
`include "cdc_consts.svh"
module cdc_top_tb_top;
   import cdc_pkg::*;
   logic clk = 0, rst = 1, stopReq = 0, errReq = 0, pb, rec, rs, sv, irq, tre, st;
   logic [7:0] sd;
   logic [11:0] inh;
   logic [31:0] rdata, v;
   logic [1:0] e = 2'h0;
   cdc_char_t lc = '0, tc;
   cdc_bus_t bus = '0;
   int fails = 0, num_checks = 0, seed = 14756, i, k, s;
   cdc_top dut (.clk(clk), .rst(rst), .lineChar(lc), .tapeChar(tc), .tapeReadErr(tre),
      .bus(bus), .rdata(rdata), .playbackOn(pb), .recordOn(rec), .recordStart(rs),
      .pbSendValid(sv), .pbSendData(sd), .irq(irq));
   cdc_tape_model tape (.clk(clk), .playbackOn(pb), .stopReq(stopReq), .errReq(errReq),
      .tapeChar(tc), .tapeReadErr(tre));
   always #10 clk = ~clk;
   task chk(input logic [31:0] g, x);
      num_checks++;
      if (g !== x)
      begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task bw(input logic [3:0] ad, input logic [31:0] d, input logic w);
      @(posedge clk) bus <= '{ad, d, w, !w};
      @(posedge clk) bus <= '{ad, d, 1'b0, 1'b0};
      #1 v = rdata;
   endtask : bw
   task ch(input int sr, input logic [7:0] d);
      @(posedge clk) lc <= '{1'b1, cdc_src_t'(sr), d};
      @(posedge clk) lc.valid <= 1'b0;
      #1 st = rs;
   endtask : ch
   // waits for a sent tape char, the stop code only unless any is set
   task wt(input logic any);
      // step off the edge so the registered send pulse has settled
      #1;
      repeat (20)
         if (sv !== 1'b1 || !any && sd !== 8'h13)
            #20;
      chk(sv, 1'b1);
   endtask : wt
   function automatic logic [1:0] nx(int c, logic [1:0] o);
      nx = o;
      nx[c % 2] = c < 2;
   endfunction : nx
   task wrap_up;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      #400000 fails++;
      wrap_up;
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bw(4'hf, 32'h0, 1'b0);
      chk({v[29:0], pb, rec}, 32'h0);
      for (i = 0; i < 40; i++)
      begin
         k = i < 4 ? i : $unsigned($random(seed)) % 4;
         s = $unsigned($random(seed)) % 3;
         inh = i < 4 ? 12'h0 : 12'($random(seed));
         bw(`CDC_ADDR_CTRL, {27'h0, 4'h8, i % 5 != 4}, 1'b1);
         bw(`CDC_ADDR_INHIBIT, {20'h0, inh}, 1'b1);
         ch(s, 8'h11 + 8'(k));
         if (i % 5 != 4 && !inh[s * 4 + k])
            e = nx(k, e);
         chk({rec, pb}, e);
      end
      bw(`CDC_ADDR_INHIBIT, 32'h0, 1'b1);
      bw(`CDC_ADDR_CTRL, 32'h11, 1'b1);
      ch(2, 8'h11);
      @(posedge clk) stopReq <= 1'b1;
      wt(1'b0);
      chk(pb, 1'b1);
      @(posedge clk) stopReq <= 1'b0;
      #1 wt(1'b1);
      #20 chk(pb, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         bw(`CDC_ADDR_CTRL, k ? 32'h11 : 32'h13, 1'b1);
         ch(2, 8'h11);
         @(posedge clk) errReq <= 1'b1;
         repeat (6) @(posedge clk);
         errReq <= 1'b0;
         #1 chk(pb, k[0]);
      end
      wt(1'b1);
      ch(1, 8'h14);
      ch(1, 8'h12);
      for (i = 1; i <= 86; i++)
      begin
         ch(1, 8'h20 + 8'($unsigned($random(seed)) % 95));
         chk(st, i == 86);
      end
      for (k = 0; k < 2; k++)
      begin
         bw(`CDC_ADDR_CTRL, k ? 32'h1d : 32'h15, 1'b1);
         ch(1, {1'b0, `CDC_CH_ETX});
         chk(st, !k[0]);
      end
      bw(`CDC_ADDR_IRQ_STAT, 32'hf, 1'b1);
      bw(`CDC_ADDR_IRQ_MASK, 32'h2, 1'b1);
      ch(2, 8'h13);
      chk(irq, 1'b0);
      ch(2, 8'h14);
      chk(irq, 1'b1);
      bw(`CDC_ADDR_IRQ_STAT, 32'h2, 1'b1);
      chk(irq, 1'b0);
      bw(`CDC_ADDR_IRQ_STAT, 32'h0, 1'b0);
      chk(v, 32'h1);
      wrap_up;
   end
endmodule : cdc_top_tb_top
`default_nettype wire
